// File: hw/cfg_load_and_irq_return_exec.sv
/*
 Execute logic for the config-load and interrupt-return instructions, plus the
 ordinary direct write/read path to the config and irq control registers.
 Assumes the fetch stage holds instr stable across all four quarter phases of a
 cycle, and the stack supplies stack_top_value combinationally from its top entry.
*/
`timescale 1ns/1ps
module cfg_load_and_irq_return_exec
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [13:0] instr,
    input wire logic [7:0] accumulator,
    input wire logic file_wr,
    input wire logic [6:0] file_addr,
    input wire logic [7:0] file_wdata,
    input wire logic [12:0] stack_top_value,
    output logic [7:0] file_rdata,
    output logic [7:0] cfg_register,
    output logic [7:0] irq_control_register,
    output logic global_irq_enable,
    output logic [12:0] pc,
    output logic pc_load,
    output logic stack_pop,
    output logic busy,
    output logic [1:0] phase_out
);
    logic [1:0] rst_sync;
    logic rst_n;
    logic [1:0] phase;
    cfg_irq_pkg::ret_state_e state;
    cfg_irq_pkg::ret_state_e next_state;
    logic [7:0] next_cfg;
    logic [7:0] next_ictl;
    logic [12:0] next_pc;
    logic next_pc_load;
    logic next_stack_pop;
    logic next_busy;
    logic [7:0] next_rdata;

    // Opcode match for the dedicated config load; only the full 14-bit word counts
    function automatic logic is_cfg_load(input logic [13:0] word);
        return word == cfg_irq_pkg::OP_CFG_LOAD;
    endfunction

    // Opcode match for the interrupt return
    function automatic logic is_irq_return(input logic [13:0] word);
        return word == cfg_irq_pkg::OP_IRQ_RETURN;
    endfunction

    // Quarter-phase compare, used by the Q4 writes, the Q1 return decode and the Q3 enable step
    function automatic logic at_phase(input logic [1:0] now, input logic [1:0] which);
        return now == which;
    endfunction

    // Address decode for the directly addressed config register
    function automatic logic hits_cfg(input logic [6:0] addr);
        return addr == cfg_irq_pkg::CFG_REG_ADDR;
    endfunction

    // Address decode for the irq control register
    function automatic logic hits_ictl(input logic [6:0] addr);
        return addr == cfg_irq_pkg::IRQ_CTRL_ADDR;
    endfunction

    // Reset release through two flops so removal is clean on our clock
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    quarter_phase u_phase
    (
        .clock(clock),
        .rst_n(rst_n),
        .phase(phase)
    );

    // Decode and execute; status flags are never touched by this block
    always_comb
    begin
        next_state = state;
        next_cfg = cfg_register;
        next_ictl = irq_control_register;
        next_pc = pc;
        next_pc_load = 1'b0;
        next_stack_pop = 1'b0;
        next_busy = busy;
        case (state)
            cfg_irq_pkg::ST_EXEC:
            begin
                // (RULE2) direct register write
                if (file_wr && at_phase(phase, cfg_irq_pkg::Q4))
                begin
                    if (hits_cfg(file_addr))
                        next_cfg = file_wdata;
                    if (hits_ictl(file_addr))
                        next_ictl = file_wdata;
                end
                // (RULE1) legacy config load
                // (RULE3) same as accumulator write
                // Placed after the direct write so the load wins a same-cycle clash
                if (is_cfg_load(instr) && at_phase(phase, cfg_irq_pkg::Q4))
                    next_cfg = accumulator;
                // (RULE6) decode in Q1
                // Later phases of a return word are ignored, so a late-held word cannot restart it
                if (is_irq_return(instr) && at_phase(phase, cfg_irq_pkg::Q1))
                begin
                    next_state = cfg_irq_pkg::ST_RET_FIRST;
                    next_busy = 1'b1;
                end
            end
            cfg_irq_pkg::ST_RET_FIRST:
            begin
                // (RULE5) enable set in Q3
                if (at_phase(phase, cfg_irq_pkg::Q3))
                    next_ictl[cfg_irq_pkg::IRQ_ENABLE_BIT] = 1'b1;
                // (RULE4) pop into PC at Q4
                if (phase == cfg_irq_pkg::Q4)
                begin
                    next_pc = stack_top_value;
                    next_pc_load = 1'b1;
                    next_stack_pop = 1'b1;
                    next_state = cfg_irq_pkg::ST_RET_SECOND;
                end
            end
            cfg_irq_pkg::ST_RET_SECOND:
            begin
                // (RULE6) second cycle idles, ends at Q4
                if (phase == cfg_irq_pkg::Q4)
                begin
                    next_state = cfg_irq_pkg::ST_EXEC;
                    next_busy = 1'b0;
                end
            end
            default:
            begin
                next_state = cfg_irq_pkg::ST_EXEC;
                next_busy = 1'b0;
            end
        endcase
    end

    // Read mux registered so every output comes from a flop; one cycle of latency
    always_comb
    begin
        if (file_addr == cfg_irq_pkg::CFG_REG_ADDR)
            next_rdata = cfg_register;
        else if (file_addr == cfg_irq_pkg::IRQ_CTRL_ADDR)
            next_rdata = irq_control_register;
        else
            next_rdata = 8'h00;
    end

    // Read data register; kept apart from the execute state so it never stalls
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            file_rdata <= 8'h00;
        else
            file_rdata <= next_rdata;
    end

    // Execute state and register outputs

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= cfg_irq_pkg::ST_EXEC;
            cfg_register <= cfg_irq_pkg::CFG_RESET;
            irq_control_register <= cfg_irq_pkg::IRQ_CTRL_RESET;
            global_irq_enable <= 1'b0;
            pc <= cfg_irq_pkg::PC_RESET;
            pc_load <= 1'b0;
            stack_pop <= 1'b0;
            busy <= 1'b0;
            phase_out <= cfg_irq_pkg::Q1;
        end
        else
        begin
            state <= next_state;
            cfg_register <= next_cfg;
            irq_control_register <= next_ictl;
            global_irq_enable <= next_ictl[cfg_irq_pkg::IRQ_ENABLE_BIT];
            pc <= next_pc;
            pc_load <= next_pc_load;
            stack_pop <= next_stack_pop;
            busy <= next_busy;
            phase_out <= phase;
        end
    end
endmodule

// File: hw/cfg_irq_pkg.sv
/*
 Constants for the configuration-load and interrupt-return execute block.
 Assumes a 14-bit instruction word, 8-bit data and a 13-bit program counter.
*/
// Overview of operation
// (RULE1) Fixed config-load opcode copies accumulator to config register, one cycle, flags untouched.
// (RULE2) Config register is also an ordinary direct file register, readable and writable.
// (RULE3) Dedicated config-load opcode kept for compatibility, same effect as register write.
// (RULE4) Interrupt-return opcode pops stack, loads popped top value into program counter.
// (RULE5) Interrupt-return sets global interrupt enable, bit 7 of irq control register.
// (RULE6) Interrupt-return takes two cycles: decode Q1, enable Q3, pop Q4, then idle.
package cfg_irq_pkg;
    localparam logic [13:0] OP_CFG_LOAD = 14'h0062;
    localparam logic [13:0] OP_IRQ_RETURN = 14'h0009;
    localparam logic [6:0] CFG_REG_ADDR = 7'h01;
    localparam logic [6:0] IRQ_CTRL_ADDR = 7'h0b;
    localparam int IRQ_ENABLE_BIT = 7;
    localparam logic [7:0] CFG_RESET = 8'hff;
    localparam logic [7:0] IRQ_CTRL_RESET = 8'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q3 = 2'h2;
    localparam logic [1:0] Q4 = 2'h3;
    localparam int IRQ_RETURN_CYCLES = 2;

    typedef enum logic [1:0]
    {
        ST_EXEC = 2'b00,
        ST_RET_FIRST = 2'b01,
        ST_RET_SECOND = 2'b10
    } ret_state_e;
endpackage

// File: hw/quarter_phase.sv
/*
 Quarter-phase counter: splits each instruction cycle into Q1..Q4.
 Assumes a synchronised active-low reset from the parent.
*/
`timescale 1ns/1ps
module quarter_phase
(
    input wire logic clock,
    input wire logic rst_n,
    output logic [1:0] phase
);
    logic [1:0] next_phase;

    // Free-running phase advance, wraps Q4 to Q1
    always_comb
    begin
        next_phase = phase + 2'h1;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            phase <= cfg_irq_pkg::Q1;
        else
            phase <= next_phase;
    end
endmodule

// File: verif/cfg_exec_checker.sv
/* Assertions on the config-load and return-from-interrupt block.
   Assumes instr is held for a whole instruction cycle. */
`timescale 1ns/1ps
module cfg_exec_checker
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [13:0] instr,
    input wire logic [7:0] accumulator,
    input wire logic file_wr,
    input wire logic [6:0] file_addr,
    input wire logic [7:0] file_wdata,
    input wire logic [12:0] stack_top_value,
    input wire logic [7:0] cfg_register,
    input wire logic [7:0] irq_control_register,
    input wire logic global_irq_enable,
    input wire logic [12:0] pc,
    input wire logic pc_load,
    input wire logic stack_pop,
    input wire logic busy,
    input wire logic [1:0] phase_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // A Q4 edge just passed with no return in flight
    sequence q4_free;
        phase_out == cfg_irq_pkg::Q4 && !$past(busy);
    endsequence
    sequence ret_hold;
        busy [*7] ##1 !busy;
    endsequence
    chk_load_copy: assert property (q4_free ##0 $past(instr) == cfg_irq_pkg::OP_CFG_LOAD
        |-> cfg_register == $past(accumulator)) else $error("config load lost");
    chk_direct_write: assert property (q4_free ##0 $past(file_wr) && $past(instr) != cfg_irq_pkg::OP_CFG_LOAD
        && $past(file_addr) == cfg_irq_pkg::CFG_REG_ADDR |-> cfg_register == $past(file_wdata))
        else $error("direct write lost");
    // Config only moves on a Q4 edge, as an ordinary write would
    chk_cfg_quiet: assert property (phase_out != cfg_irq_pkg::Q4 |-> $stable(cfg_register))
        else $error("config changed off Q4");
    chk_pop_load: assert property ($rose(busy) |-> ##3 stack_pop && pc_load
        && pc == $past(stack_top_value) ##1 !stack_pop) else $error("pop or pc load wrong");
    chk_gie_set: assert property ($rose(busy) |-> ##2 irq_control_register[7] ##1 global_irq_enable)
        else $error("enable not set");
    chk_two_cycles: assert property ($rose(busy) |-> ret_hold) else $error("return length wrong");
endmodule
bind cfg_load_and_irq_return_exec cfg_exec_checker cfg_exec_checker_i (.*);

// File: verif/cfg_load_and_irq_return_exec_tb.sv
/* Self-checking bench for the config-load and return-from-interrupt block.
   Assumes phase_out shows the quarter phase of the last clock edge. */
`timescale 1ns/1ps
module cfg_load_and_irq_return_exec_tb;
    typedef struct packed
    {
        logic [13:0] op;
        logic [7:0] acc;
        logic wr;
        logic [6:0] addr;
        logic [7:0] wdata;
        logic [7:0] cfg;
        logic [7:0] rd;
    } row_s;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic [7:0] accumulator = 8'h00;
    logic file_wr = 1'b0;
    logic [6:0] file_addr = 7'h00;
    logic [7:0] file_wdata = 8'h00;
    logic [12:0] stack_top_value = 13'h0abc;
    logic [7:0] file_rdata, cfg_register, irq_control_register;
    logic global_irq_enable, pc_load, stack_pop, busy;
    logic [12:0] pc;
    logic [1:0] phase_out;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    // Read data lags a cycle, so rd holds the state before the row
    row_s rows [4] = '{'{14'h0062, 8'h5a, 1'b0, 7'h01, 8'h00, 8'h5a, 8'hff},
        '{14'h0000, 8'h33, 1'b1, 7'h01, 8'hc3, 8'hc3, 8'h5a},
        '{14'h0062, 8'h81, 1'b1, 7'h01, 8'h11, 8'h81, 8'hc3},
        '{14'h0000, 8'h00, 1'b1, 7'h0b, 8'h00, 8'h81, 8'h00}};
    always #2.5 clock = ~clock;
    cfg_load_and_irq_return_exec cfg_load_and_irq_return_exec_i (.*);
    task automatic check(string name, logic [12:0] seen, logic [12:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One instruction cycle, entered just after a Q4 edge
    task automatic issue(logic [13:0] op, logic [7:0] acc, logic wr, logic [6:0] addr, logic [7:0] wdata);
        instr <= op;
        accumulator <= acc;
        file_wr <= wr;
        file_addr <= addr;
        file_wdata <= wdata;
        repeat (4) @(posedge clock);
        #1;
    endtask
    // Bound on the run so a stuck phase cannot hang it
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 400)
        begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        do
        begin
            @(posedge clock);
            #1;
        end
        while (phase_out !== cfg_irq_pkg::Q4);
        check("cfg reset", cfg_register, cfg_irq_pkg::CFG_RESET);
        foreach (rows[i])
        begin
            issue(rows[i].op, rows[i].acc, rows[i].wr, rows[i].addr, rows[i].wdata);
            check("cfg", cfg_register, rows[i].cfg);
            check("rdata", file_rdata, rows[i].rd);
        end
        issue(cfg_irq_pkg::OP_IRQ_RETURN, 8'h00, 1'b0, cfg_irq_pkg::IRQ_CTRL_ADDR, 8'h00);
        check("pc", pc, 13'h0abc);
        check("pop", stack_pop, 1'b1);
        check("irq enable", global_irq_enable, 1'b1);
        check("irq ctl", irq_control_register, 8'h80);
        check("pc load", pc_load, 1'b1);
        // Second return cycle must swallow this load
        issue(cfg_irq_pkg::OP_CFG_LOAD, 8'h77, 1'b1, cfg_irq_pkg::CFG_REG_ADDR, 8'h44);
        check("busy", busy, 1'b0);
        check("cfg held", cfg_register, 8'h81);
        tally_and_finish();
    end
endmodule
